// >>> hdl/nri_cfg.svh
`ifndef NRI_CFG_SVH
`define NRI_CFG_SVH
// Flash commands and address cycles
`define NRI_CMD_RESET    8'hFF
`define NRI_CMD_READ_ID  8'h90
`define NRI_CMD_PARAM    8'hEC
`define NRI_CMD_STATUS   8'h70
`define NRI_CMD_READMODE 8'h00
`define NRI_CMD_RNDOUT1  8'h05
`define NRI_CMD_RNDOUT2  8'hE0
`define NRI_ADDR_ID_MFR  8'h00
`define NRI_ADDR_ID_ONFI 8'h20
`define NRI_ADDR_PARAM   8'h00
// Register byte addresses
`define NRI_REG_CTRL     12'h000
`define NRI_REG_STAT     12'h004
`define NRI_REG_DATA     12'h008
`define NRI_REG_COL      12'h00C
// Control fields
`define NRI_CTRL_OP_LSB  0
`define NRI_CTRL_OP_MSB  2
`define NRI_CTRL_CNT_LSB 8
`define NRI_CTRL_CNT_MSB 17
// Operation codes
`define NRI_OP_RESET     3'h1
`define NRI_OP_ID_MFR    3'h2
`define NRI_OP_ID_ONFI   3'h3
`define NRI_OP_PARAM     3'h4
`define NRI_OP_RANDOM    3'h5
`define NRI_OP_STATUS    3'h6
// Pin timing in ns and in cycles of the 50 ns clock
`define NRI_CLK_NS       50
`define NRI_T_SETUP_NS   50
`define NRI_T_SETUP_CYC  ((`NRI_T_SETUP_NS + `NRI_CLK_NS - 1) / `NRI_CLK_NS)
`define NRI_T_RST_MAX_NS 1000000
`define NRI_T_RST_CYC    (`NRI_T_RST_MAX_NS / `NRI_CLK_NS)
`define NRI_T_WB_CYC     4
`endif

// >>> hdl/nri_pkg.sv
package nri_pkg;
  typedef struct packed {
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       re_n;
    logic       wp_n;
    logic [7:0] io_out;
    logic       io_oe_n;
  } nri_pins_t;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,
    ST_CMD   = 4'b0001,
    ST_ADDR  = 4'b0010,
    ST_CMD2  = 4'b0011,
    ST_BUSY  = 4'b0100,
    ST_RDLO  = 4'b0101,
    ST_RDHI  = 4'b0110,
    ST_STROB = 4'b0111,
    ST_WHI   = 4'b1000,
    ST_GAP   = 4'b1001
  } nri_state_t;
endpackage : nri_pkg

// >>> hdl/nri_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "nri_cfg.svh"
module nri_host #(
  parameter int RST_CYC = `NRI_T_RST_CYC
) (
  // System
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Flash pins
  output nri_pkg::nri_pins_t     pins,
  input  wire logic [7:0]        io_in,
  input  wire logic              rb_n,
  input  wire logic              wp_req
);
  import nri_pkg::*;

  // Synchronisers for pins
  logic [7:0] io_s1_reg, io_s2_reg;
  logic       rb_s1_reg, rb_s2_reg;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      io_s1_reg <= 8'h00;
      io_s2_reg <= 8'h00;
      rb_s1_reg <= 1'b0;
      rb_s2_reg <= 1'b0;
    end else begin
      io_s1_reg <= io_in;
      io_s2_reg <= io_s1_reg;
      rb_s1_reg <= rb_n;
      rb_s2_reg <= rb_s1_reg;
    end
  end

  // Sequencer state
  nri_state_t  st_reg, st_next;
  logic [2:0]  op_reg, op_next;
  logic [9:0]  cnt_reg, cnt_next;      // bytes still to read
  logic [9:0]  col_reg, col_next;      // column for random read
  logic [7:0]  data_reg, data_next;
  logic        dvalid_reg, dvalid_next;
  logic        done_reg, done_next;
  logic        tout_reg, tout_next;
  logic        init_reg, init_next;    // reset has been sent
  logic        err_reg, err_next;
  logic [19:0] tmr_reg, tmr_next;
  logic [1:0]  step_reg, step_next;    // cycle within command or address
  logic [1:0]  acnt_reg, acnt_next;    // command and address cycles sent
  nri_pins_t   pins_reg, pins_next;

  wire logic wr_acc = psel & penable & pwrite;
  wire logic rd_acc = psel & penable & ~pwrite;
  wire logic busy   = (st_reg != ST_IDLE);
  wire logic [2:0] new_op = pwdata[`NRI_CTRL_OP_MSB:`NRI_CTRL_OP_LSB];
  // First command byte of each operation
  function automatic logic [7:0] first_cmd(input logic [2:0] op);
    unique case (op)
      `NRI_OP_RESET:   first_cmd = `NRI_CMD_RESET;
      `NRI_OP_ID_MFR,
      `NRI_OP_ID_ONFI: first_cmd = `NRI_CMD_READ_ID;
      `NRI_OP_PARAM:   first_cmd = `NRI_CMD_PARAM;
      `NRI_OP_RANDOM:  first_cmd = `NRI_CMD_RNDOUT1;
      default:         first_cmd = `NRI_CMD_STATUS;
    endcase
  endfunction : first_cmd
  // Next-state logic
  always_comb begin
    st_next     = st_reg;
    op_next     = op_reg;
    cnt_next    = cnt_reg;
    col_next    = col_reg;
    data_next   = data_reg;
    dvalid_next = dvalid_reg;
    done_next   = done_reg;
    tout_next   = tout_reg;
    init_next   = init_reg;
    err_next    = err_reg;
    tmr_next    = tmr_reg;
    step_next   = step_reg;
    acnt_next   = acnt_reg;
    pins_next   = pins_reg;
    pins_next.wp_n = ~wp_req;
    if (rd_acc && paddr == `NRI_REG_DATA) begin
      dvalid_next = 1'b0;
    end
    if (wr_acc && paddr == `NRI_REG_COL) begin
      col_next = pwdata[9:0];
    end
    if (wr_acc && paddr == `NRI_REG_STAT) begin
      done_next = 1'b0;
      err_next  = 1'b0;
      tout_next = 1'b0;
    end
    unique case (st_reg)
      ST_IDLE: begin
        if (wr_acc && paddr == `NRI_REG_CTRL) begin
          // Refuse anything but reset until reset was sent
          if (!init_reg && new_op != `NRI_OP_RESET) begin
            err_next = 1'b1;
          // Identifier and parameter only with device ready
          end else if ((new_op == `NRI_OP_ID_MFR || new_op == `NRI_OP_ID_ONFI ||
                        new_op == `NRI_OP_PARAM) && !rb_s2_reg) begin
            err_next = 1'b1;
          end else begin
            op_next        = new_op;
            cnt_next       = pwdata[`NRI_CTRL_CNT_MSB:`NRI_CTRL_CNT_LSB];
            done_next      = 1'b0;
            pins_next.ce_n = 1'b0;
            st_next        = ST_CMD;
            step_next      = 2'd0;
          end
        end
      end
      ST_CMD, ST_CMD2, ST_ADDR: begin
        // Write cycle: setup with we low, then we high latches byte
        pins_next.cle     = (st_reg != ST_ADDR);
        pins_next.ale     = (st_reg == ST_ADDR);
        pins_next.io_oe_n = 1'b0;
        if (st_reg == ST_CMD)  pins_next.io_out = first_cmd(op_reg);
        if (st_reg == ST_CMD2) pins_next.io_out = (op_reg == `NRI_OP_RANDOM) ?
                                 `NRI_CMD_RNDOUT2 : `NRI_CMD_READMODE;
        if (st_reg == ST_ADDR) begin
          unique case (op_reg)
            `NRI_OP_ID_MFR:  pins_next.io_out = `NRI_ADDR_ID_MFR;
            `NRI_OP_ID_ONFI: pins_next.io_out = `NRI_ADDR_ID_ONFI;
            `NRI_OP_RANDOM:  pins_next.io_out = (acnt_reg == 2'd1) ?
                               col_reg[7:0] : {6'h00, col_reg[9:8]};
            default:         pins_next.io_out = `NRI_ADDR_PARAM;
          endcase
        end
        pins_next.we_n = (step_reg == 2'd0) ? 1'b0 : 1'b1;
        step_next      = step_reg + 2'd1;
        if (step_reg == 2'd1) begin
          step_next     = 2'd0;
          st_next       = ST_GAP;  // Latch lines stay up through the rising strobe
          tmr_next      = 20'(`NRI_T_WB_CYC);
        end
      end
      ST_GAP: begin
        // Drop latch lines, release the bus, then pick the next cycle
        pins_next.cle     = 1'b0;
        pins_next.ale     = 1'b0;
        pins_next.io_oe_n = 1'b1;
        tmr_next          = tmr_reg - 20'd1;
        if (tmr_reg == 20'd0) begin
          acnt_next = acnt_reg + 2'd1;
          unique case (op_reg)
            `NRI_OP_RESET: begin
              init_next = 1'b1;
              st_next   = ST_BUSY;
              tmr_next  = 20'(RST_CYC);
            end
            `NRI_OP_STATUS: st_next = ST_RDLO;
            `NRI_OP_PARAM:  st_next = (acnt_reg == 2'd0) ? ST_ADDR : ST_BUSY;
            `NRI_OP_RANDOM: st_next = (acnt_reg == 2'd2) ? ST_CMD2 :
                                      (acnt_reg == 2'd3) ? ST_RDLO : ST_ADDR;
            default:        st_next = (acnt_reg == 2'd0) ? ST_ADDR : ST_RDLO;
          endcase
          if (st_next == ST_BUSY || st_next == ST_RDLO) acnt_next = 2'd0;
        end
      end
      ST_BUSY: begin
        // Wait for ready; only a reset wait is bounded by the reset limit
        tmr_next = (tmr_reg == 20'd0) ? 20'd0 : tmr_reg - 20'd1;
        if (rb_s2_reg) begin
          st_next = (op_reg == `NRI_OP_PARAM) ? ST_RDLO : ST_IDLE;
          if (op_reg != `NRI_OP_PARAM) begin
            done_next      = 1'b1;
            pins_next.ce_n = 1'b1;
          end
        end else if (op_reg == `NRI_OP_RESET && tmr_reg == 20'd0) begin
          tout_next      = 1'b1;
          done_next      = 1'b1;
          st_next        = ST_IDLE;
          pins_next.ce_n = 1'b1;
        end
      end
      ST_RDLO: begin
        // Read strobe low; wait for software to drain data first
        if (cnt_reg == 10'd0) begin
          done_next      = 1'b1;
          st_next        = ST_IDLE;
          pins_next.ce_n = (op_reg == `NRI_OP_RESET);
        end else if (!dvalid_reg) begin
          pins_next.re_n = 1'b0;
          st_next        = ST_STROB;
          tmr_next       = 20'(`NRI_T_SETUP_CYC);
        end
      end
      ST_STROB: begin
        tmr_next = tmr_reg - 20'd1;
        if (tmr_reg == 20'd0) st_next = ST_RDHI;
      end
      ST_RDHI: begin
        // Capture byte, raise strobe, device advances its pointer
        data_next      = io_s2_reg;
        dvalid_next    = 1'b1;
        pins_next.re_n = 1'b1;
        cnt_next       = cnt_reg - 10'd1;
        st_next        = ST_RDLO;
      end
      default: st_next = ST_IDLE;
    endcase
    // Reset may be forced from any state
    if (wr_acc && paddr == `NRI_REG_CTRL && busy && new_op == `NRI_OP_RESET) begin
      op_next        = `NRI_OP_RESET;
      cnt_next       = 10'd0;
      acnt_next      = 2'd0;
      step_next      = 2'd0;
      pins_next.ce_n = 1'b0;
      pins_next.re_n = 1'b1;
      pins_next.we_n = 1'b1;                                           // Keeps strobe one cycle
      st_next        = ST_CMD;
    end
  end

  // Registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_reg     <= ST_IDLE;
      op_reg     <= 3'h0;
      cnt_reg    <= 10'd0;
      col_reg    <= 10'd0;
      data_reg   <= 8'h00;
      dvalid_reg <= 1'b0;
      done_reg   <= 1'b0;
      tout_reg   <= 1'b0;
      init_reg   <= 1'b0;
      err_reg    <= 1'b0;
      tmr_reg    <= 20'd0;
      step_reg   <= 2'd0;
      acnt_reg   <= 2'd0;
      pins_reg   <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1,
                      wp_n: 1'b0, io_out: 8'h00, io_oe_n: 1'b1};
    end else begin
      st_reg     <= st_next;
      op_reg     <= op_next;
      cnt_reg    <= cnt_next;
      col_reg    <= col_next;
      data_reg   <= data_next;
      dvalid_reg <= dvalid_next;
      done_reg   <= done_next;
      tout_reg   <= tout_next;
      init_reg   <= init_next;
      err_reg    <= err_next;
      tmr_reg    <= tmr_next;
      step_reg   <= step_next;
      acnt_reg   <= acnt_next;
      pins_reg   <= pins_next;
    end
  end

  // APB answer: zero wait, unmapped reads zero with error
  always_comb begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    unique case (paddr)
      `NRI_REG_CTRL: prdata = {14'h0000, cnt_reg, 5'h00, op_reg};
      `NRI_REG_STAT: prdata = {21'h00_0000, rb_s2_reg, init_reg, tout_reg,
                               err_reg, dvalid_reg, done_reg, busy, 4'h0};
      `NRI_REG_DATA: prdata = {24'h00_0000, data_reg};
      `NRI_REG_COL:  prdata = {22'h00_0000, col_reg};
      default:       pslverr = psel & penable;
    endcase
  end
  assign pready = 1'b1;
  assign pins   = pins_reg;
endmodule : nri_host
`default_nettype wire

// >>> dv/nri_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module nri_asserts (
  // System
  input wire logic               clk_sys,
  input wire logic               reset_n,
  // APB
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  // Flash pins
  input wire nri_pkg::nri_pins_t pins
);
  import nri_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic seen_rst_reg;
  // Remembers that a reset command went out
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) seen_rst_reg <= 1'b0;
    else if (pins.cle && !pins.we_n && pins.io_out == 8'hFF) seen_rst_reg <= 1'b1;
  end
  // Command byte latched by the device
  sequence s_cmd; $rose(pins.we_n) && pins.cle; endsequence
  property p_rst_first; s_cmd |-> seen_rst_reg || pins.io_out == 8'hFF; endproperty
  a_rst_first: assert property (p_rst_first) else $error("command before reset");
  property p_no_78; s_cmd |-> pins.io_out != 8'h78; endproperty
  a_no_78: assert property (p_no_78) else $error("enhanced status sent");
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("apb wait state");
  property p_unmap; psel && penable && paddr[11:4] != 8'h00 |-> pslverr; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access accepted");
  property p_unmap_rd; psel && penable && !pwrite && paddr[11:4] != 8'h00 |-> prdata == '0;
  endproperty
  a_unmap_rd: assert property (p_unmap_rd) else $error("unmapped read not zero");
  property p_drive; pins.cle || pins.ale |-> !pins.io_oe_n; endproperty
  a_drive: assert property (p_drive) else $error("bus not driven in write cycle");
  property p_release; !pins.re_n |-> pins.io_oe_n; endproperty
  a_release: assert property (p_release) else $error("bus driven during read");
  property p_we; $fell(pins.we_n) |=> $rose(pins.we_n); endproperty
  a_we: assert property (p_we) else $error("write strobe not one cycle");
  property p_re; $fell(pins.re_n) |=> !pins.re_n ##[1:8] pins.re_n; endproperty
  a_re: assert property (p_re) else $error("read strobe length wrong");
  // Main scenarios
  c_rst: cover property (s_cmd ##0 pins.io_out == 8'hFF);
  c_id: cover property (s_cmd ##0 pins.io_out == 8'h90);
  c_par: cover property (s_cmd ##0 pins.io_out == 8'hEC);
endmodule : nri_asserts
`default_nettype wire

// >>> dv/nri_flash.sv
`timescale 1ns/1ps
`default_nettype none
module nri_flash #(
  parameter logic [7:0] MAKER  = 8'h3C, // Arbitrary code
  parameter logic [7:0] DEVID  = 8'hA1, // Arbitrary code
  parameter int         RST_NS = 1000,
  parameter int         TR_NS  = 2000
) (
  // Host side
  input  wire nri_pkg::nri_pins_t pins,
  input  wire logic               slow,
  // Device answers
  output logic [7:0]              io_in,
  output logic                    rb_n
);
  import nri_pkg::*;
  logic [7:0]  cmd = '0;
  logic [7:0]  cur = '0;
  logic [7:0]  last = '0;
  logic [7:0]  stat = '0;
  logic [15:0] col = '0;
  int          mode = 0;
  int          ptr = 0;
  int          gen = 0;
  // Ready at power-up
  initial rb_n = 1'b1;
  // Busy window; a later one cancels an earlier one
  task automatic go_busy(input int ns);
    int g;
    gen++;
    g = gen;
    rb_n = 1'b0;
    fork
      begin
        #(ns);
        if (g == gen) rb_n = 1'b1;
      end
    join_none
  endtask : go_busy
  // Byte under the pointer in the current mode
  function automatic logic [7:0] rd_byte(input int p);
    logic [7:0] s [4];
    s = '{8'h4F, 8'h4E, 8'h46, 8'h49};
    case (mode)
      1: return p == 0 ? MAKER : p == 1 ? DEVID : p == 2 ? {1'b1, 1'b0, 2'b01, 4'b0000}
        : p == 3 ? {1'b1, 1'b0, 2'b01, 1'b0, 1'b1, 2'b01} : 8'h00;
      2: return p < 4 ? s[p] : ~last;
      3: return p % 256 < 4 ? s[p % 256] : 8'(p % 256) ^ 8'h5A;
      4: return stat;
      default: return ~last;
    endcase
  endfunction : rd_byte
  // Command and address cycles latch on the rising write strobe
  always @(posedge pins.we_n) begin
    if (!pins.ce_n && pins.cle && (rb_n || pins.io_out inside {8'hFF, 8'h70})) begin
      cmd = pins.io_out;
      if (cmd == 8'hFF) begin
        mode = 0;
        stat = pins.wp_n ? 8'hE0 : 8'h60;
        go_busy(slow ? 5000 : RST_NS);
      end
      if (cmd == 8'h70) mode = 4;
      if (cmd == 8'hE0) ptr = int'(col);
    end
    if (!pins.ce_n && pins.ale) begin
      if (cmd == 8'h90) mode = pins.io_out == 8'h00 ? 1 : pins.io_out == 8'h20 ? 2 : 0;
      if (cmd == 8'hEC && pins.io_out == 8'h00) begin
        mode = 3;
        go_busy(TR_NS);
      end
      if (cmd == 8'h05) col = {pins.io_out, col[15:8]};
      else ptr = 0;
    end
  end
  // One byte per read strobe
  always @(negedge pins.re_n) cur = rd_byte(ptr);
  always @(posedge pins.re_n) begin
    last = cur;
    ptr++;
  end
  // Wire level; a released bus shows the inverse of the last byte
  assign io_in = !pins.io_oe_n ? pins.io_out : (!pins.re_n && !pins.ce_n) ? cur : ~last;
endmodule : nri_flash
`default_nettype wire

// >>> dv/nri_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
module nri_host_tb;
  import nri_pkg::*;
  localparam logic [7:0] MK = 8'h3C; // Arbitrary code
  localparam logic [7:0] DV = 8'hA1; // Arbitrary code
  localparam logic [7:0] IDV [5] = '{MK, DV, 8'h90, {2'b10, 2'b01, 4'b0101}, 8'h00};
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        wp_req = 1'b0;
  logic        slow = 1'b0;
  logic        pready, pslverr, rb_n, e;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, d;
  logic [31:0] lfsr = 32'hc717_7eca;
  logic [7:0]  io_in, b, col;
  nri_pins_t   pins;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          n;
  // Clock
  always #25 clk_sys = ~clk_sys;
  nri_host #(.RST_CYC(50)) dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins), .io_in(io_in), .rb_n(rb_n),
    .wp_req(wp_req));
  nri_flash #(.MAKER(MK), .DEVID(DV)) flash_u (.pins(pins), .slow(slow), .io_in(io_in),
    .rb_n(rb_n));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  function automatic logic [7:0] exp_pg(input int q);
    logic [7:0] s [4];
    s = '{8'h4F, 8'h4E, 8'h46, 8'h49};
    return q % 256 < 4 ? s[q % 256] : 8'(q % 256) ^ 8'h5A;
  endfunction : exp_pg
  task automatic final_report();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // Cycle ceiling against hangs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic waitb(input int i, input logic v);
    do apb(1'b0, 12'h004, '0); while (d[i] !== v);
  endtask : waitb
  task automatic op(input logic [2:0] o, input int c);
    apb(1'b1, 12'h004, '0);
    apb(1'b1, 12'h000, {14'h0, c[9:0], 5'h0, o});
  endtask : op
  task automatic rd_chk(input int c, input int base, input logic id);
    for (int i = 0; i < c; i++) begin
      waitb(6, 1'b1);
      apb(1'b0, 12'h008, '0);
      b = d[7:0];
      chk(b, id ? IDV[i] : exp_pg(base + i));
    end
  endtask : rd_chk
  initial begin
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    op(3'h2, 5);
    apb(1'b0, 12'h004, '0);
    chk(d[7], 1'b1);
    $display("test first_cmd done");
    for (int w = 0; w < 2; w++) begin
      wp_req <= w[0];
      op(3'h1, 0);
      waitb(5, 1'b1);
      chk(d[9:8], 2'b10);
      op(3'h6, 1);
      rd_chk(0, 0, 1'b0);
      waitb(6, 1'b1);
      apb(1'b0, 12'h008, '0);
      chk(d[7:0], w ? 8'h60 : 8'hE0);
    end
    $display("test reset done");
    op(3'h2, 5);
    rd_chk(5, 0, 1'b1);
    op(3'h3, 4);
    rd_chk(4, 0, 1'b0);
    lfsr = nxt(lfsr);
    n = 250 + int'(lfsr[3:0]);
    op(3'h4, n);
    rd_chk(n, 0, 1'b0);
    lfsr = nxt(lfsr);
    col = lfsr[7:0];
    apb(1'b1, 12'h00C, {24'h0, col});
    op(3'h5, 6);
    rd_chk(6, int'(col), 1'b0);
    $display("test read done");
    op(3'h4, 4);
    waitb(10, 1'b0);
    apb(1'b1, 12'h000, 32'h1);
    waitb(5, 1'b1);
    chk(d[6], 1'b0);
    op(3'h3, 4);
    rd_chk(4, 0, 1'b0);
    slow <= 1'b1;
    op(3'h1, 0);
    waitb(8, 1'b1);
    chk(d[9:8], 2'b11);
    slow <= 1'b0;
    $display("test abort done");
    lfsr = nxt(lfsr);
    apb(1'b1, 12'h010, lfsr);
    chk(e, 1'b1);
    apb(1'b0, 12'h7F0, '0);
    chk({e, d[30:0]}, 32'h8000_0000);
    $display("test bus done");
    final_report();
  end
endmodule : nri_host_tb
bind nri_host nri_asserts chk_u (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pins(pins));
`default_nettype wire
